// ==== float_operand_format_regs.sv ====
// Operand format front end and programming-model storage of a float coprocessor
// Assumes: register port master per house bus; host keeps memory byte order
// Operation
// - Single 32-bit and double 64-bit formats
// - Normalized significand has hidden leading one
// - True exponent is field minus bias
// - All-ones exponent reserved; zero exponent rules
// - Top bit is sign; negate flips it
// - Normal value: sign, scaled, one plus fraction
// - Positive and negative zero both recognised
// - Infinity, NaN, denormal are reserved
// - Reserved operand traps unless plain move
// - Never deliver infinity, NaN or denormal
// - Two's complement integers, 8/16/32 bits
// - Negative integer is pattern minus two-power
// - Eight 64-bit data registers
// - Integer register operands are host registers
// - Double register pair: even low, odd high
// - Status is 32 bits, modified flag 16
// - Rounding field bits 8:7 selects mode
// - Trap type cleared on clean finish
// - Underflow disabled gives exact zero
// - Write to data register sets modified flag
`timescale 1ns/1ps
`default_nettype none
module float_operand_format_regs
  import fp_format_pkg::*;
(
  input  wire logic        clock,           // 250 MHz core clock
  input  wire logic        nrst,            // Asynchronous reset, active low
  input  wire logic [7:0]  reg_addr,        // Register port address
  input  wire logic [31:0] reg_wdata,       // Register port write data
  input  wire logic        reg_write,       // Write strobe
  input  wire logic        reg_read,        // Read strobe
  output logic      [31:0] reg_rdata,       // Read data, cycle after strobe
  input  wire logic        instr_done,      // Instruction finished pulse
  input  wire logic        instr_is_move,   // Finishing instr is plain move
  input  wire logic        instr_is_status, // Finishing instr loads or stores status
  input  wire logic        instr_double,    // Operand is double precision
  input  wire logic [63:0] instr_operand,   // Operand of the finishing instr
  input  wire logic        instr_underflow, // Result too small to normalize
  input  wire logic        result_write,    // Result write to data register
  input  wire logic [2:0]  result_reg,      // Destination register number
  input  wire logic        result_double,   // Result is double precision
  input  wire logic [63:0] result_value,    // Result value from datapath
  output logic      [63:0] result_stored,   // Value actually written (sanitized)
  output logic             invalid_trap,    // Invalid-operation trap pulse
  output logic             underflow_trap,  // Underflow trap pulse
  output logic      [1:0]  rounding_select  // Current rounding mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoded view of a floating operand
  typedef struct packed {
    logic              sign;      // Sign bit
    logic [10:0]       exp;       // Biased exponent field
    logic [51:0]       frac;      // Fraction, left aligned
    operand_class_type cls;       // Class
    logic [12:0]       true_exp;  // Signed true exponent
    logic [52:0]       signif;    // Significand with hidden one
  } decoded_type;

  // State of the block, except hi_pending, hi_addr, hi_data and the data memory
  typedef struct packed {
    logic [31:0] status;        // Status and control word
    logic [31:0] rdata;         // Read data register
    logic        rd_mem;        // Read data comes from memory
    logic [63:0] class_op;      // Classifier operand
    logic        class_dbl;     // Classifier precision
    logic [1:0]  class_ilen;    // Classifier integer length
    logic [63:0] stored;        // Last stored result
    logic        inv_trap;      // Invalid trap pulse
    logic        uf_trap;       // Underflow trap pulse
  } state_type;

  state_type state_reg;    // Registered state
  state_type state_next;   // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Split and classify an operand in either format
  function automatic decoded_type decode(input logic [63:0] op, input logic dbl);
    decoded_type d;
    logic        exp_ones;
    logic        exp_zero;
    logic        frac_zero;
    d = '0;
    if (dbl) begin
      d.sign = op[63];
      d.exp  = op[62:52];
      d.frac = op[51:0];
      d.true_exp = 13'(signed'({2'h0, d.exp}) - signed'({2'h0, double_bias}));
      exp_ones = &op[62:52];
    end else begin
      d.sign = op[31];
      d.exp  = {3'h0, op[30:23]};
      d.frac = {op[22:0], 29'h0};
      d.true_exp = 13'(signed'({2'h0, d.exp}) - signed'({2'h0, single_bias}));
      exp_ones = &op[30:23];
    end
    exp_zero  = (d.exp == 11'h000);
    frac_zero = (d.frac == 52'h0);
    d.signif  = {1'b1, d.frac};
    if (exp_ones) begin
      d.cls = class_reserved;
    end else if (exp_zero && frac_zero) begin
      d.cls = class_zero;
    end else if (exp_zero) begin
      d.cls = class_reserved;
    end else begin
      d.cls = class_normal;
    end
    return d;
  endfunction : decode

  // Sign-extend an integer of the chosen length to 32 bits
  function automatic logic [31:0] int_value(input logic [31:0] op, input logic [1:0] len);
    logic [31:0] v;
    case (len)
      int_byte:  v = {{24{op[7]}}, op[7:0]};
      int_word:  v = {{16{op[15]}}, op[15:0]};
      int_dword: v = op;
      default:   v = op;
    endcase
    return v;
  endfunction : int_value

  ////////////////////////////////////////////////////////////////////////////
  // Data register memory wiring
  logic        mem_wr_en;    // Memory write enable
  logic [3:0]  mem_wr_addr;  // Memory write address
  logic [31:0] mem_wr_data;  // Memory write data
  logic [3:0]  mem_rd_addr;  // Memory read address
  logic [31:0] mem_rd_data;  // Memory read data
  logic        hi_pending;   // Second half of a double result due
  logic [3:0]  hi_addr;      // Address of that half
  logic [31:0] hi_data;      // Data of that half

  decoded_type res_dec;      // Result classification
  decoded_type ins_dec;      // Instruction operand classification
  decoded_type cls_dec;      // Classifier port view
  logic [63:0] res_clean;    // Sanitized result

  assign res_dec = decode(result_value, result_double);
  assign ins_dec = decode(instr_operand, instr_double);
  assign cls_dec = decode(state_reg.class_op, state_reg.class_dbl);

  // Reserved results are replaced by a signed zero; underflow with the trap disabled by positive zero
  always_comb begin
    if (res_dec.cls == class_reserved) begin
      res_clean = result_double ? {result_value[63], 63'h0}
                                : {32'h0, result_value[31], 31'h0};
    end else if (instr_underflow && !state_reg.status[uen_bit]) begin
      res_clean = 64'h0;
    end else begin
      res_clean = result_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory port selection: results take priority, bus writes next
  logic bus_data_wr;  // Bus write to a data word
  logic bus_data_hit; // Bus address within data words
  assign bus_data_hit = (reg_addr[7:4] == addr_data_base[7:4]);
  assign bus_data_wr  = reg_write && bus_data_hit;

  always_comb begin
    mem_wr_en   = 1'b0;
    mem_wr_addr = 4'h0;
    mem_wr_data = 32'h0;
    if (hi_pending) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = hi_addr;
      mem_wr_data = hi_data;
    end else if (result_write) begin
      mem_wr_en   = 1'b1;
      // Double result: low half in even word, high half next
      mem_wr_addr = {result_reg, 1'b0};
      mem_wr_data = res_clean[31:0];
    end else if (bus_data_wr) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = reg_addr[3:0];
      mem_wr_data = reg_wdata;
    end
  end

  // Second cycle of a double result write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hi_pending <= 1'b0;
      hi_addr    <= 4'h0;
      hi_data    <= 32'h0;
    end else begin
      hi_pending <= result_write && result_double && !hi_pending;
      hi_addr    <= {result_reg, 1'b1};
      hi_data    <= res_clean[63:32];
    end
  end

  assign mem_rd_addr = reg_addr[3:0];

  fp_data_mem #(
    .words (16),
    .aw    (4)
  ) u_mem (
    .clock   (clock),
    .nrst    (nrst),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [31:0] st;
    logic [31:0] cres;
    st          = state_reg.status;
    cres        = 32'h0;
    state_next  = state_reg;
    state_next.inv_trap = 1'b0;
    state_next.uf_trap  = 1'b0;
    state_next.rd_mem   = 1'b0;

    // Software write to status: reserved bits dropped
    if (reg_write && reg_addr == addr_status) begin
      st = reg_wdata & status_wmask;
    end

    // Completion of an instruction other than a status load or store updates the trap type field
    if (instr_done && !instr_is_status) begin
      if (!instr_is_move && ins_dec.cls == class_reserved) begin
        st[trap_lsb +: 3]   = trap_invalid;
        state_next.inv_trap = 1'b1;
      end else if (instr_underflow) begin
        st[trap_lsb +: 3] = trap_underflow;
        st[uf_bit]        = 1'b1;
        state_next.uf_trap = st[uen_bit];
      end else begin
        st[trap_lsb +: 3] = trap_none;
      end
    end

    // Any data register write sets the modified flag; set wins
    if (result_write || bus_data_wr) begin
      st[rmb_bit] = 1'b1;
    end
    state_next.status = st;

    // Classifier port writes
    if (reg_write) begin
      case (reg_addr)
        addr_class:     state_next.class_op[31:0]  = reg_wdata;
        addr_class_hi:  state_next.class_op[63:32] = reg_wdata;
        addr_class_ctl: begin
          state_next.class_dbl  = reg_wdata[0];
          state_next.class_ilen = reg_wdata[2:1];
        end
        default: ;
      endcase
    end

    // Underflow with trap disabled stores exact zero
    if (result_write) begin
      state_next.stored = res_clean;
    end

    // Classifier result word
    cres[1:0]   = cls_dec.cls;
    cres[2]     = cls_dec.sign;
    cres[15:3]  = cls_dec.true_exp;
    cres[31:16] = 16'(cls_dec.signif[52:37]);

    // Read decode; data words come from memory a cycle later
    if (reg_read) begin
      case (reg_addr)
        addr_status:    state_next.rdata = state_reg.status & status_wmask;
        addr_class:     state_next.rdata = state_reg.class_op[31:0];
        addr_class_hi:  state_next.rdata = state_reg.class_op[63:32];
        addr_class_ctl: state_next.rdata = {29'h0, state_reg.class_ilen,
                                            state_reg.class_dbl};
        addr_class_res: state_next.rdata = cres;
        addr_int_val:   state_next.rdata = int_value(state_reg.class_op[31:0],
                                                     state_reg.class_ilen);
        default: begin
          state_next.rdata  = 32'h0;
          state_next.rd_mem = bus_data_hit;
        end
      endcase
    end else begin
      state_next.rdata = 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg        <= '0;
      state_reg.status <= status_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata       = state_reg.rd_mem ? mem_rd_data : state_reg.rdata;
  assign result_stored   = state_reg.stored;
  assign invalid_trap    = state_reg.inv_trap;
  assign underflow_trap  = state_reg.uf_trap;
  assign rounding_select = state_reg.status[rnd_lsb +: 2];

endmodule : float_operand_format_regs
`default_nettype wire

// ==== fp_format_pkg.sv ====
// Package: constants for the float operand format and status register block
// Assumes: included by the data register memory and the main block
package fp_format_pkg;

  // Register bus addresses
  localparam logic [7:0]  addr_status      = 8'h00;  // Status and control word
  localparam logic [7:0]  addr_data_base   = 8'h10;  // Data words: base + 2*reg + half
  localparam logic [7:0]  addr_class       = 8'h04;  // Classifier operand low word
  localparam logic [7:0]  addr_class_hi    = 8'h05;  // Classifier operand high word
  localparam logic [7:0]  addr_class_ctl   = 8'h06;  // Classifier control
  localparam logic [7:0]  addr_class_res   = 8'h07;  // Classifier result
  localparam logic [7:0]  addr_int_val     = 8'h08;  // Integer value result

  // Status register fields
  localparam int          trap_lsb         = 0;
  localparam int          uen_bit          = 3;
  localparam int          uf_bit           = 4;
  localparam int          ien_bit          = 5;
  localparam int          if_bit           = 6;
  localparam int          rnd_lsb          = 7;
  localparam int          swf_lsb          = 9;
  localparam int          rmb_bit          = 16;
  localparam logic [31:0] status_wmask     = 32'h0001_ffff;
  localparam logic [31:0] status_reset     = 32'h0000_0000;

  // Trap type codes
  localparam logic [2:0]  trap_none        = 3'h0;
  localparam logic [2:0]  trap_underflow   = 3'h1;
  localparam logic [2:0]  trap_invalid     = 3'h5;

  // Rounding selections
  localparam logic [1:0]  rnd_nearest      = 2'h0;
  localparam logic [1:0]  rnd_zero         = 2'h1;
  localparam logic [1:0]  rnd_pos          = 2'h2;
  localparam logic [1:0]  rnd_neg          = 2'h3;

  // Format geometry
  localparam int          single_exp_w     = 8;
  localparam int          single_frac_w    = 23;
  localparam int          double_exp_w     = 11;
  localparam int          double_frac_w    = 52;
  localparam logic [10:0] single_bias      = 11'h07f;
  localparam logic [10:0] double_bias      = 11'h3ff;

  // Integer length codes
  localparam logic [1:0]  int_byte         = 2'h0;
  localparam logic [1:0]  int_word         = 2'h1;
  localparam logic [1:0]  int_dword        = 2'h3;

  // Operand classes
  typedef enum logic [1:0] {
    class_normal,
    class_zero,
    class_reserved
  } operand_class_type;

endpackage : fp_format_pkg

// ==== fp_data_mem.sv ====
// Memory of 32-bit halves backing the eight 64-bit data registers
// Assumes: one write and one read port on the same clock; read data registered
`timescale 1ns/1ps
`default_nettype none
module fp_data_mem
  import fp_format_pkg::*;
#(
  parameter int words = 16,
  parameter int aw    = 4
) (
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          wr_en,
  input  wire logic [aw-1:0] wr_addr,
  input  wire logic [31:0]   wr_data,
  input  wire logic [aw-1:0] rd_addr,
  output logic      [31:0]   rd_data
);

  logic [31:0] mem [words];  // Storage array, not reset

  //////////////////////////////////////////////////////////////////////////
  // Write port
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered read port
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : fp_data_mem
`default_nettype wire

// ==== float_format_chk.sv ====
// Checker: port assertions for the float operand format block
// Assumes: one clock, reset asynchronous and active low
`timescale 1ns/1ps
`default_nettype none
module float_format_chk
  import fp_format_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        instr_done,
  input wire logic        instr_is_move,
  input wire logic        instr_is_status,
  input wire logic        instr_double,
  input wire logic [63:0] instr_operand,
  input wire logic        instr_underflow,
  input wire logic        result_write,
  input wire logic [2:0]  result_reg,
  input wire logic        result_double,
  input wire logic [63:0] result_value,
  input wire logic [63:0] result_stored,
  input wire logic        invalid_trap,
  input wire logic        underflow_trap,
  input wire logic [1:0]  rounding_select
);
  // Single domain for every property
  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  // Finishing instruction that may trap on its operand
  wire logic trapping = instr_done && !instr_is_move && !instr_is_status;
  // Double result write without underflow
  wire logic dbl_wr   = result_write && result_double && !instr_underflow;

  ////////////////////////////////////////////////////////////////////////
  // Trap pulses
  trap_cause_a:
    assert property (invalid_trap |-> $past(instr_done) && !$past(instr_is_move))
    else $error("invalid trap without a finishing operation");
  move_quiet_a:
    assert property (instr_done && instr_is_move |=> !invalid_trap)
    else $error("plain move raised a trap");
  ones_trap_a:
    assert property (trapping && !instr_double && instr_operand[30:23] == 8'hff |=> invalid_trap)
    else $error("all-ones single exponent did not trap");
  denorm_trap_a:
    assert property (trapping && instr_double && instr_operand[62:52] == 11'h0
      && instr_operand[51:0] != 52'h0 |=> invalid_trap)
    else $error("double denormal did not trap");
  zero_quiet_a:
    assert property (instr_done && !instr_double && instr_operand[30:0] == 31'h0 |=> !invalid_trap)
    else $error("signed zero trapped");
  uf_trap_a:
    assert property (underflow_trap |-> $past(instr_done) && $past(instr_underflow))
    else $error("underflow trap without underflow");

  ////////////////////////////////////////////////////////////////////////
  // Stored results
  no_special_a:
    assert property ($past(result_write) && $past(result_double) |-> result_stored[62:52] != 11'h7ff
      && !(result_stored[62:52] == 11'h0 && result_stored[51:0] != 52'h0))
    else $error("special value stored");
  res_zero_a:
    assert property (dbl_wr && result_value[62:52] == 11'h7ff |=> result_stored[62:0] == 63'h0
      && result_stored[63] == $past(result_value[63]))
    else $error("reserved result not turned to signed zero");
  pass_val_a:
    assert property (dbl_wr && result_value[62:52] != 11'h7ff && result_value[62:52] != 11'h0
      |=> result_stored == $past(result_value))
    else $error("normal result altered");

  ////////////////////////////////////////////////////////////////////////
  // Status register
  rnd_load_a:
    assert property (reg_write && reg_addr == addr_status |=> rounding_select == $past(reg_wdata[8:7]))
    else $error("rounding field not loaded");
  resv_zero_a:
    assert property (reg_read && reg_addr == addr_status |=> reg_rdata[31:17] == 15'h0)
    else $error("reserved status bits not zero");

  // Main scenarios
  cover property (invalid_trap);
  cover property (underflow_trap);
  cover property (result_write && result_double);
endmodule : float_format_chk

bind float_operand_format_regs float_format_chk u_chk (.*);
`default_nettype wire

// ==== host_bus_model.sv ====
// Partner: host processor model that masters the register port
// Assumes: the block answers a read in the following cycle, never stalls
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import fp_format_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [31:0] reg_rdata,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_write,
  output logic             reg_read
);
  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end

  // One-cycle write; data is scrambled once released
  task automatic bus_write(input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= wd;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~wd;
  endtask : bus_write

  // One-cycle read; answer taken in the following cycle
  task automatic bus_read(input logic [7:0] a, output logic [31:0] rd);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    rd = reg_rdata;
  endtask : bus_read

  // Operand handed over low word first, integers like memory data
  task automatic put_operand(input logic [63:0] op, input logic [7:0] ctl);
    bus_write(addr_class, op[31:0]);
    bus_write(addr_class_hi, op[63:32]);
    bus_write(addr_class_ctl, {24'h0, ctl});
  endtask : put_operand
endmodule : host_bus_model
`default_nettype wire

// ==== testbench.sv ====
// Testbench: drives the float operand format block and checks its ports
// Assumes: host model owns the register port; bench owns datapath ports
`timescale 1ns/1ps
`default_nettype none
`define expect_eq(what, expv, gotv) begin \
  n_compared++; \
  if ((gotv) !== (expv)) begin \
    failures++; \
    $display("unexpected %s expected %h seen %h", what, expv, gotv); \
  end \
end
module testbench
  import fp_format_pkg::*;
;
  // Classifier case: control, operand, result address, mask, expected
  typedef struct {
    logic [7:0]  ctl;
    logic [63:0] opnd;
    logic [7:0]  raddr;
    logic [31:0] mask;
    logic [31:0] expv;
  } row_type;
  logic        clock;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        reg_write, reg_read;
  logic        instr_done = 1'b0, instr_is_move = 1'b0, instr_is_status = 1'b0;
  logic        instr_double = 1'b0, instr_underflow = 1'b0;
  logic [63:0] instr_operand = 64'h0, result_value = 64'h0, result_stored, v;
  logic        result_write = 1'b0, result_double = 1'b0;
  logic [2:0]  result_reg = 3'h0;
  logic        invalid_trap, underflow_trap;
  logic [1:0]  rounding_select;
  logic [31:0] d;
  int          failures = 0;
  int          n_compared = 0;
  row_type     rows [14] = '{
    '{8'h00, 64'h3f40_0000, addr_class_res, 32'hffff_ffff, 32'hc000_fff8},
    '{8'h00, 64'hc040_0000, addr_class_res, 32'h0000_ffff, 32'h0000_000c},
    '{8'h00, 64'h0080_0000, addr_class_res, 32'h0000_ffff, 32'h0000_fc10},
    '{8'h00, 64'h0000_0000, addr_class_res, 32'h0000_0007, 32'h0000_0001},
    '{8'h00, 64'h8000_0000, addr_class_res, 32'h0000_0007, 32'h0000_0005},
    '{8'h00, 64'h7f80_0000, addr_class_res, 32'h0000_0003, 32'h0000_0002},
    '{8'h00, 64'h0000_0001, addr_class_res, 32'h0000_0003, 32'h0000_0002},
    '{8'h01, 64'h4008_0000_0000_0000, addr_class_res, 32'hffff, 32'h0008},
    '{8'h01, 64'h3ff0_0000_7f80_0000, addr_class_res, 32'hffff, 32'h0000},
    '{8'h01, 64'h0000_0000_0000_0001, addr_class_res, 32'h0003, 32'h0002},
    '{8'h00, 64'h0000_0080, addr_int_val, 32'hffff_ffff, 32'hffff_ff80},
    '{8'h00, 64'h0000_007f, addr_int_val, 32'hffff_ffff, 32'h0000_007f},
    '{8'h02, 64'h1234_8001, addr_int_val, 32'hffff_ffff, 32'hffff_8001},
    '{8'h06, 64'h8000_0000, addr_int_val, 32'hffff_ffff, 32'h8000_0000}};

  float_operand_format_regs dut (.*);
  host_bus_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));

  ////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // One-cycle datapath step: finishing instruction and/or result write
  task automatic op(input logic dn, mv, st, dbl, uf, input logic [63:0] opnd,
                    input logic wr, input logic [2:0] rg, input logic [63:0] val);
    @(posedge clock);
    {instr_done, instr_is_move, instr_is_status, instr_double, instr_underflow}
      <= {dn, mv, st, dbl, uf};
    {result_write, result_double, result_reg, result_value, instr_operand}
      <= {wr, dbl, rg, val, opnd};
    @(posedge clock);
    {instr_done, result_write} <= 2'b00;
    @(negedge clock);
  endtask : op

  // Counts, verdict and end of run
  task automatic final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    host.bus_read(addr_status, d);
    `expect_eq("status at reset", status_reset, d)
    for (int m = 0; m < 4; m++) begin
      host.bus_write(addr_status, 32'(m) << rnd_lsb);
      host.bus_read(addr_status, d);
      `expect_eq("rounding", 2'(m), rounding_select)
    end
    host.bus_write(addr_status, 32'hffff_ffff);
    host.bus_read(addr_status, d);
    `expect_eq("status mask", status_wmask, d)
    host.bus_write(addr_status, 32'h0);
    $display("status tests done");
    foreach (rows[i]) begin
      host.put_operand(rows[i].opnd, rows[i].ctl);
      host.bus_read(rows[i].raddr, d);
      `expect_eq("classifier", rows[i].expv, d & rows[i].mask)
    end
    $display("classifier rows done");
    for (int r = 0; r < 8; r++) begin
      v = {32'h4010_0000 + 32'(r), 32'h1234_5670 + 32'(r)};
      op(0, 0, 0, 1, 0, 64'h0, 1, 3'(r), v);
      `expect_eq("stored", v, result_stored)
      host.bus_read(addr_data_base + 8'(2 * r), d);
      `expect_eq("low half", v[31:0], d)
      host.bus_read(addr_data_base + 8'(2 * r + 1), d);
      `expect_eq("high half", v[63:32], d)
    end
    host.bus_read(addr_status, d);
    `expect_eq("modified flag", 1'b1, d[rmb_bit])
    op(0, 0, 0, 1, 0, 64'h0, 1, 3'h3, 64'hfff8_0000_0000_0000);
    `expect_eq("nan result", 64'h8000_0000_0000_0000, result_stored)
    op(0, 0, 0, 1, 0, 64'h0, 1, 3'h3, 64'h0000_0000_0000_0001);
    `expect_eq("denormal result", 64'h0, result_stored)
    host.bus_write(addr_data_base + 8'h0e, 32'h0bad_f00d);
    host.bus_read(addr_data_base + 8'h0e, d);
    `expect_eq("bus data word", 32'h0bad_f00d, d)
    host.bus_write(8'h40, 32'hffff_ffff);
    host.bus_read(8'h40, d);
    `expect_eq("unmapped", 32'h0, d)
    $display("data register tests done");
    op(1, 0, 0, 0, 0, 64'h7f80_0000, 0, 3'h0, 64'h0);
    `expect_eq("invalid pulse", 1'b1, invalid_trap)
    host.bus_read(addr_status, d);
    `expect_eq("trap code", trap_invalid, d[2:0])
    op(1, 0, 1, 0, 0, 64'h3f80_0000, 0, 3'h0, 64'h0);
    host.bus_read(addr_status, d);
    `expect_eq("trap after status op", trap_invalid, d[2:0])
    op(1, 0, 0, 0, 0, 64'h8000_0000, 0, 3'h0, 64'h0);
    `expect_eq("zero pulse", 1'b0, invalid_trap)
    host.bus_read(addr_status, d);
    `expect_eq("trap cleared", trap_none, d[2:0])
    op(1, 1, 0, 0, 0, 64'h7fc0_0000, 0, 3'h0, 64'h0);
    `expect_eq("move pulse", 1'b0, invalid_trap)
    op(1, 0, 0, 1, 0, 64'h0000_0000_0000_0001, 0, 3'h0, 64'h0);
    `expect_eq("double denormal", 1'b1, invalid_trap)
    op(1, 0, 0, 1, 0, 64'h3ff0_0000_7f80_0000, 0, 3'h0, 64'h0);
    `expect_eq("double width", 1'b0, invalid_trap)
    $display("trap tests done");
    host.bus_write(addr_status, 32'h0);
    v = 64'h3ff0_0000_0000_0001;
    op(1, 0, 0, 1, 1, v, 1, 3'h1, v);
    `expect_eq("underflow zero", 64'h0, result_stored)
    `expect_eq("underflow quiet", 1'b0, underflow_trap)
    host.bus_read(addr_status, d);
    `expect_eq("underflow code", trap_underflow, d[2:0])
    host.bus_write(addr_status, 32'h1 << uen_bit);
    op(1, 0, 0, 1, 1, v, 1, 3'h1, v);
    `expect_eq("underflow trap", 1'b1, underflow_trap)
    host.bus_write(addr_status, 32'h180);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    host.bus_read(addr_status, d);
    `expect_eq("status after reset", status_reset, d)
    `expect_eq("rounding after reset", rnd_nearest, rounding_select)
    $display("underflow and reset tests done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
